// ===== rtl/top_trace_port.sv
// trace observation port: gated equal-latency trace pipeline, trace stall control, apb registers
// How it works
// - enable high: monitored core signals flow through to the trace outputs
// - enable low: traceOut holds its last value; traceProcessId still follows register writes
// - all traced signals pass the same number of register stages
// - trace buffer full input stalls the core
// - stall lasts while buffer full stays high, released after it drops
// - stall only taken at an instruction boundary, bus transfer completes first
// - config bits give normal and fast interrupts priority over the stall
// - software-writable trace process identifier shown to trace tools
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module top_trace_port
  import top_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trace_port_enable,
  input wire logic trace_buffer_full,
  input wire logic normal_interrupt_request_low,
  input wire logic fast_interrupt_request_low,
  input wire logic instrBoundary,
  input wire logic busXferActive,
  input wire logic [TOP_MON_W-1:0] coreMonitor,
  output logic [TOP_MON_W-1:0] traceOut,
  output logic [31:0] traceProcessId,
  output logic coreStall
);
  typedef struct packed {
    logic [2:0] enSync;
    logic [2:0] fullSync;
    logic enStable;
    logic fullStable;
    logic [1:0] cfg;
    logic [31:0] pid;
    logic stall;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } top_state_t;
  top_state_t s_q;
  top_state_t s_d;
  logic [TOP_MON_W-1:0] stageData [0:TOP_PIPE_STAGES];
  logic irqPending;
  logic apbAccess;

  // register read mux, decoded once
  function automatic logic [31:0] readMux(input logic [11:0] a, input top_state_t s,
                                          output logic bad);
    logic [31:0] r;
    r = 32'h0000_0000;
    bad = 1'b0;
    unique case (a)
      TOP_ADDR_CFG: r[1:0] = s.cfg;
      TOP_ADDR_PID: r = s.pid;
      TOP_ADDR_STAT: begin
        r[TOP_STAT_STALL_BIT] = s.stall;
        r[TOP_STAT_FULL_BIT] = s.fullStable;
        r[TOP_STAT_EN_BIT] = s.enStable;
      end
      default: bad = 1'b1;
    endcase
    return r;
  endfunction : readMux

  assign apbAccess = psel && penable && !s_q.ready;
  // interrupts enabled for priority break through the stall
  assign irqPending = (s_q.cfg[TOP_CFG_IRQ_PRI_BIT] && !normal_interrupt_request_low) ||
                      (s_q.cfg[TOP_CFG_FIQ_PRI_BIT] && !fast_interrupt_request_low);

  // next state: synchronisers, stall control, apb slave
  always_comb begin
    logic bad;
    logic [31:0] rd;
    bad = 1'b0;
    rd = 32'h0000_0000;
    s_d = s_q;
    s_d.enSync = {s_q.enSync[1:0], trace_port_enable};
    s_d.fullSync = {s_q.fullSync[1:0], trace_buffer_full};
    if (s_q.enSync[1] == s_q.enSync[2]) begin
      s_d.enStable = s_q.enSync[2];
    end
    if (s_q.fullSync[1] == s_q.fullSync[2]) begin
      s_d.fullStable = s_q.fullSync[2];
    end
    // stall entry only between instructions with the bus idle
    if (!s_q.stall) begin
      if (s_q.fullStable && instrBoundary && !busXferActive && !irqPending) begin
        s_d.stall = 1'b1;
      end
    end else if (!s_q.fullStable || irqPending) begin
      s_d.stall = 1'b0;
    end
    // apb: one wait state, answer on the second access cycle
    s_d.ready = apbAccess;
    s_d.err = 1'b0;
    if (apbAccess) begin
      rd = readMux(paddr, s_q, bad);
      s_d.err = bad;
      s_d.rdata = pwrite ? 32'h0000_0000 : rd;
      if (pwrite && !bad) begin
        unique case (paddr)
          TOP_ADDR_CFG: s_d.cfg = pwdata[1:0];
          TOP_ADDR_PID: s_d.pid = pwdata;
          default: ;
        endcase
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.cfg <= TOP_CFG_RESET;
      s_q.pid <= TOP_PID_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // equal-depth gated pipeline on the traced signals
  assign stageData[0] = coreMonitor;
  for (genvar i = 0; i < TOP_PIPE_STAGES; i++) begin : gPipe
    top_pipe_stage #(.W(TOP_MON_W)) uStage (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .enable(s_q.enStable),
      .dIn(stageData[i]),
      .dOut(stageData[i+1])
    );
  end

  assign traceOut = stageData[TOP_PIPE_STAGES];
  assign traceProcessId = s_q.pid;
  assign coreStall = s_q.stall;
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
endmodule : top_trace_port
`default_nettype wire

// ===== inc/top_pkg.sv
// package for the trace observation port: register map, field layout, reset values
`default_nettype none
package top_pkg;
  localparam int TOP_MON_W = 32;
  localparam int TOP_PIPE_STAGES = 2;
  localparam logic [11:0] TOP_ADDR_CFG = 12'h000;
  localparam logic [11:0] TOP_ADDR_PID = 12'h004;
  localparam logic [11:0] TOP_ADDR_STAT = 12'h008;
  localparam int TOP_CFG_IRQ_PRI_BIT = 0;
  localparam int TOP_CFG_FIQ_PRI_BIT = 1;
  localparam logic [1:0] TOP_CFG_RESET = 2'h0;
  localparam logic [31:0] TOP_PID_RESET = 32'h0000_0000;
  localparam int TOP_STAT_STALL_BIT = 0;
  localparam int TOP_STAT_FULL_BIT = 1;
  localparam int TOP_STAT_EN_BIT = 2;
endpackage : top_pkg
`default_nettype wire

// ===== rtl/top_pipe_stage.sv
// one gated pipeline stage of the trace output register chain
`timescale 1ns/10ps
`default_nettype none
module top_pipe_stage
  import top_pkg::*;
#(
  parameter int W = TOP_MON_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [W-1:0] dIn,
  output logic [W-1:0] dOut
);
  typedef struct packed {
    logic [W-1:0] data;
  } top_stage_t;
  top_stage_t s_q;
  top_stage_t s_d;

  // load when enabled, otherwise hold last value
  always_comb begin
    s_d = s_q;
    if (enable) begin
      s_d.data = dIn;
    end
  end

  // synchronous clear to zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dOut = s_q.data;
endmodule : top_pipe_stage
`default_nettype wire

// ===== bench/top_trace_port_properties.sv
// trace port checker
`timescale 1ns/10ps
`default_nettype none
module top_props
  import top_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic coreStall,
  input wire logic trace_port_enable,
  input wire logic trace_buffer_full,
  input wire logic instrBoundary,
  input wire logic busXferActive,
  input wire logic normal_interrupt_request_low,
  input wire logic fast_interrupt_request_low,
  input wire logic [TOP_MON_W-1:0] coreMonitor,
  input wire logic [TOP_MON_W-1:0] traceOut
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // pin levels held long enough to cross the synchronisers
  sequence enOn; trace_port_enable [*8]; endsequence
  sequence fullOn; trace_buffer_full [*6]; endsequence
  sequence fullOff; !trace_buffer_full [*6]; endsequence
  rdy_pulse_a: assert property (pready |=> !pready) else $error("long pready");
  rdy_time_a: assert property (psel && penable && !pready |=> pready) else $error("no pready");
  trace_flow_a:
    assert property (enOn |-> traceOut == $past(coreMonitor, 2)) else $error("lag");
  trace_freeze_a:
    assert property (!trace_port_enable [*6] |-> $stable(traceOut)) else $error("moved");
  reset_clear_a:
    assert property (disable iff (1'b0) !rst_n |=> traceOut == 0 && !coreStall) else $error("rst");
  stall_entry_a:
    assert property (fullOn ##0 (instrBoundary && !busXferActive && normal_interrupt_request_low
      && fast_interrupt_request_low) |=> coreStall) else $error("no stall");
  stall_release_a: assert property (fullOff |-> !coreStall) else $error("stuck");
  stall_edge_a:
    assert property ($rose(coreStall) |-> $past(instrBoundary && !busXferActive)) else $error("edge");
endmodule : top_props
bind top_trace_port top_props u_props (.*);
`default_nettype wire

// ===== bench/top_tracer.sv
// trace capture unit model
`timescale 1ns/10ps
`default_nettype none
module top_tracer (
  input wire logic tracer_power_down, fillHigh,
  output logic trace_port_enable, trace_buffer_full
);
  // enable is inverted power down; full raised at the watermark
  assign trace_port_enable = !tracer_power_down;
  assign trace_buffer_full = fillHigh;
endmodule : top_tracer
`default_nettype wire

// ===== bench/top_trace_port_tb.sv
// trace port bench
`timescale 1ns/10ps
`default_nettype none
module top_trace_port_tb;
  import top_pkg::*;
  logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, coreStall;
  logic pwrDn = 1, fill = 0, instrBoundary = 0, busXferActive = 0, trace_port_enable;
  logic normal_interrupt_request_low = 1, fast_interrupt_request_low = 1, trace_buffer_full;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, coreMonitor = 32'h0, traceOut, traceProcessId;
  int error_cnt = 0, n_tests = 0, k;
  always #5 clk_sys = ~clk_sys;
  top_tracer tu (.tracer_power_down(pwrDn), .fillHigh(fill), .trace_port_enable, .trace_buffer_full);
  top_trace_port dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .trace_port_enable(trace_port_enable),
    .trace_buffer_full(trace_buffer_full),
    .normal_interrupt_request_low(normal_interrupt_request_low),
    .fast_interrupt_request_low(fast_interrupt_request_low),
    .instrBoundary(instrBoundary),
    .busXferActive(busXferActive),
    .coreMonitor(coreMonitor),
    .traceOut(traceOut),
    .traceProcessId(traceProcessId),
    .coreStall(coreStall)
  );
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin error_cnt++; $display("wrong value %0t %h", $time, g); end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic wt(input int n); repeat (n) @(posedge clk_sys); endtask : wt
  // apb transfer; error flag folded into read bit 0
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys) penable <= 1;
    k = 0;
    do begin @(posedge clk_sys); k++; end while (pready !== 1 && k < 9);
    if (pready !== 1) begin error_cnt++; give_verdict; end
    rd = prdata ^ {31'h0, pslverr};
    psel <= 0; penable <= 0; @(posedge clk_sys);
  endtask : apb
  task automatic t_regs;
    chk(traceOut, 0);
    apb(1, TOP_ADDR_PID, 32'hA5C3_0F1E); apb(0, TOP_ADDR_PID, 0);
    chk(rd, 32'hA5C3_0F1E);
    chk(traceProcessId, 32'hA5C3_0F1E);
    apb(0, 12'h0FC, 0); chk(rd, 1);
    $display("regs end");
  endtask : t_regs
  task automatic t_trace;
    pwrDn <= 0; coreMonitor <= 32'h1234_5678;
    wt(9); chk(traceOut, 32'h1234_5678);
    coreMonitor <= 32'hCAFE_0001;
    wt(2); chk(traceOut, 32'h1234_5678);
    wt(1); chk(traceOut, 32'hCAFE_0001);
    pwrDn <= 1; wt(6); coreMonitor <= 32'h5A5A_5A5A;
    wt(8); chk(traceOut, 32'hCAFE_0001);
    $display("trace end");
  endtask : t_trace
  task automatic t_stall;
    instrBoundary <= 1; busXferActive <= 1; fill <= 1;
    wt(8); chk(coreStall, 0);
    busXferActive <= 0; wt(2); chk(coreStall, 1);
    wt(9); chk(coreStall, 1);
    fill <= 0; wt(7); chk(coreStall, 0);
    apb(1, TOP_ADDR_CFG, 32'h1); normal_interrupt_request_low <= 0; fill <= 1;
    wt(8); chk(coreStall, 0);
    normal_interrupt_request_low <= 1; wt(2); chk(coreStall, 1);
    apb(0, TOP_ADDR_STAT, 0); chk(rd, 32'h0000_0003);
    apb(1, TOP_ADDR_CFG, 32'h2); apb(0, TOP_ADDR_CFG, 0); chk(rd, 32'h0000_0002);
    fast_interrupt_request_low <= 0; wt(2); chk(coreStall, 0);
    fast_interrupt_request_low <= 1; wt(2); chk(coreStall, 1);
    $display("stall end");
  endtask : t_stall
  initial begin
    wt(12); rst_n <= 1; wt(1);
    t_regs; t_trace; t_stall;
    give_verdict;
  end
endmodule : top_trace_port_tb
`default_nettype wire
